// ### rtl/eirq_ctrl.v
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eirq_regs.vh"
module eirq_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_req_line_a,
	input wire ext_req_line_b,
	input wire [27:0] pin_change_inputs,
	input wire [15:0] periph_req,
	input wire vector_taken,
	input wire cpu_reset_entry,
	input wire wake_done,
	output reg irq_req,
	output reg [6:0] irq_vector,
	output reg wake_req
);
	reg [3:0] sense;
	reg [1:0] line_enable;
	reg [3:0] grp_enable;
	reg global_enable;
	reg [7:0] pin_group_zero_select;
	reg [7:0] pin_group_one_select;
	reg [7:0] pin_group_two_select;
	reg [3:0] pin_group_three_select;
	reg [1:0] line_flag;
	reg [1:0] lines_prev;
	reg [27:0] pins_prev;
	reg wr_addr_held;
	reg wr_data_held;
	reg [7:0] wr_addr;
	reg [31:0] wr_data;
	reg wr_addr_far;
	reg wr_strb_lo;
	reg [6:0] next_vector;
	reg next_req;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	wire [1:0] lines_sync;
	wire [27:0] pins_sync;
	wire [3:0] grp_flag;
	wire [1:0] line_level;
	wire [1:0] line_edge;
	wire [1:0] line_pend;
	wire [18:0] pend;
	wire wr_go;
	wire wr_ok;
	wire [1:0] flag_wr_clr;
	wire [3:0] grp_wr_clr;
	wire [3:0] grp_vec_clr;
	integer i;
	integer k;

	// Pins are sampled whatever their output driver does
	eirq_sync #(.WIDTH(2)) u_line_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({ext_req_line_b, ext_req_line_a}),
		.q(lines_sync)
	);
	eirq_sync #(.WIDTH(28)) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(pin_change_inputs),
		.q(pins_sync)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			lines_prev <= 2'h0;
			pins_prev <= 28'h0;
		end else begin
			lines_prev <= lines_sync;
			pins_prev <= pins_sync;
		end
	end

	// Edge sense from synchronised samples, so needs aclk running
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_line
			wire [1:0] mode;
			assign mode = sense[2*g+1:2*g];
			assign line_level[g] = (mode == `EIRQ_SENSE_LOW) && !lines_sync[g];
			assign line_edge[g] = (mode == `EIRQ_SENSE_ANY && (lines_sync[g] ^ lines_prev[g])) ||
				(mode == `EIRQ_SENSE_FALL && !lines_sync[g] && lines_prev[g]) ||
				(mode == `EIRQ_SENSE_RISE && lines_sync[g] && !lines_prev[g]);
		end
	endgenerate

	assign wr_go = wr_addr_held && wr_data_held && !s_axi_bvalid;
	// Strobe taken with the data; far addresses must not alias onto registers
	assign wr_ok = wr_go && wr_strb_lo && !wr_addr_far;
	assign flag_wr_clr = (wr_ok && wr_addr == `EIRQ_OFS_EXT_FLAG) ? wr_data[1:0] : 2'h0;
	assign grp_wr_clr = (wr_ok && wr_addr == `EIRQ_OFS_GRP_FLAG) ? wr_data[3:0] : 4'h0;
	assign grp_vec_clr = {4{vector_taken}} & {
		irq_vector == (`EIRQ_VEC_GROUP0 + 7'h3),
		irq_vector == (`EIRQ_VEC_GROUP0 + 7'h2),
		irq_vector == (`EIRQ_VEC_GROUP0 + 7'h1),
		irq_vector == `EIRQ_VEC_GROUP0};

	always @(posedge aclk) begin
		if (!aresetn) begin
			line_flag <= 2'h0;
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				if (sense[2*i+1 -: 2] == `EIRQ_SENSE_LOW)
					line_flag[i] <= 1'b0;
				else if (line_edge[i])
					line_flag[i] <= 1'b1;
				else if (flag_wr_clr[i] || (vector_taken && irq_vector == `EIRQ_VEC_LINE_A + i[6:0]))
					line_flag[i] <= 1'b0;
			end
		end
	end

	eirq_group #(.WIDTH(8)) u_grp0 (.aclk(aclk), .aresetn(aresetn), .pins(pins_sync[7:0]),
		.pins_prev(pins_prev[7:0]), .select(pin_group_zero_select),
		.clear(grp_wr_clr[0] | grp_vec_clr[0]), .flag(grp_flag[0]));
	eirq_group #(.WIDTH(8)) u_grp1 (.aclk(aclk), .aresetn(aresetn), .pins(pins_sync[15:8]),
		.pins_prev(pins_prev[15:8]), .select(pin_group_one_select),
		.clear(grp_wr_clr[1] | grp_vec_clr[1]), .flag(grp_flag[1]));
	eirq_group #(.WIDTH(8)) u_grp2 (.aclk(aclk), .aresetn(aresetn), .pins(pins_sync[23:16]),
		.pins_prev(pins_prev[23:16]), .select(pin_group_two_select),
		.clear(grp_wr_clr[2] | grp_vec_clr[2]), .flag(grp_flag[2]));
	eirq_group #(.WIDTH(4)) u_grp3 (.aclk(aclk), .aresetn(aresetn), .pins(pins_sync[27:24]),
		.pins_prev(pins_prev[27:24]), .select(pin_group_three_select),
		.clear(grp_wr_clr[3] | grp_vec_clr[3]), .flag(grp_flag[3]));

	// Level only counts while still present; gone level leaves no pending
	assign line_pend = (line_flag | line_level) & line_enable;
	assign pend = {periph_req[12:0], grp_flag & grp_enable, line_pend} & {19{global_enable}};

	// Fixed priority: lowest index, lowest address
	always @* begin
		next_req = 1'b0;
		next_vector = `EIRQ_VEC_RESET;
		for (k = `EIRQ_NUM_SRC - 1; k >= 0; k = k - 1) begin
			if (pend[k]) begin
				next_req = 1'b1;
				next_vector = k[6:0] + 7'h01;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn || cpu_reset_entry) begin
			irq_req <= 1'b0;
			irq_vector <= `EIRQ_VEC_RESET;
			wake_req <= 1'b0;
		end else begin
			irq_req <= next_req && !vector_taken;
			irq_vector <= next_vector;
			// Raw wake from synchronised levels; would be asynchronous in silicon
			wake_req <= !wake_done && ((|(pins_sync ^ pins_prev) && |grp_enable) ||
				|(line_level & line_enable));
		end
	end

	// AXI4-Lite write channel, address and data in any order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			wr_addr_held <= 1'b0;
			wr_data_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0;
			wr_addr_far <= 1'b0;
			wr_strb_lo <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr[7:0];
				wr_addr_far <= |s_axi_awaddr[31:8];
				wr_addr_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb_lo <= s_axi_wstrb[0];
				wr_data_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr_far || wr_addr > `EIRQ_OFS_PINS || wr_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
				wr_addr_held <= 1'b0;
				wr_data_held <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			sense <= `EIRQ_RST_SENSE;
			line_enable <= 2'h0;
			grp_enable <= 4'h0;
			global_enable <= 1'b0;
			pin_group_zero_select <= `EIRQ_RST_SELECT;
			pin_group_one_select <= `EIRQ_RST_SELECT;
			pin_group_two_select <= `EIRQ_RST_SELECT;
			pin_group_three_select <= 4'h0;
		end else if (wr_ok) begin
			case (wr_addr)
			`EIRQ_OFS_SENSE: sense <= wr_data[3:0];
			`EIRQ_OFS_ENABLE: line_enable <= wr_data[1:0];
			`EIRQ_OFS_GRP_ENABLE: grp_enable <= wr_data[3:0];
			`EIRQ_OFS_SEL0: pin_group_zero_select <= wr_data[7:0];
			`EIRQ_OFS_SEL1: pin_group_one_select <= wr_data[7:0];
			`EIRQ_OFS_SEL2: pin_group_two_select <= wr_data[7:0];
			`EIRQ_OFS_SEL3: pin_group_three_select <= wr_data[3:0];
			`EIRQ_OFS_GLOBAL: global_enable <= wr_data[`EIRQ_GLOBAL_BIT];
			default: global_enable <= global_enable;
			endcase
		end
	end

	always @* begin
		next_rresp = 2'h0;
		case (s_axi_araddr[7:0])
		`EIRQ_OFS_SENSE: next_rdata = {28'h0, sense};
		`EIRQ_OFS_ENABLE: next_rdata = {30'h0, line_enable};
		`EIRQ_OFS_EXT_FLAG: next_rdata = {30'h0, line_flag};
		`EIRQ_OFS_GRP_ENABLE: next_rdata = {28'h0, grp_enable};
		`EIRQ_OFS_GRP_FLAG: next_rdata = {28'h0, grp_flag};
		`EIRQ_OFS_SEL0: next_rdata = {24'h0, pin_group_zero_select};
		`EIRQ_OFS_SEL1: next_rdata = {24'h0, pin_group_one_select};
		`EIRQ_OFS_SEL2: next_rdata = {24'h0, pin_group_two_select};
		`EIRQ_OFS_SEL3: next_rdata = {28'h0, pin_group_three_select};
		`EIRQ_OFS_GLOBAL: next_rdata = {31'h0, global_enable};
		`EIRQ_OFS_PEND: next_rdata = {13'h0, pend};
		`EIRQ_OFS_PINS: next_rdata = {2'h0, lines_sync, pins_sync};
		default: begin
			next_rdata = 32'h0;
			next_rresp = 2'h2;
		end
		endcase
		// No aliasing through the upper address bits
		if (s_axi_araddr[31:8] != 24'h0) begin
			next_rdata = 32'h0;
			next_rresp = 2'h2;
		end
	end

	// Read channel: one cycle to answer
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### pkg/eirq_regs.vh
`ifndef EIRQ_REGS_VH
`define EIRQ_REGS_VH

// Byte offsets of the register words
`define EIRQ_OFS_SENSE 8'h00
`define EIRQ_OFS_ENABLE 8'h04
`define EIRQ_OFS_EXT_FLAG 8'h08
`define EIRQ_OFS_GRP_ENABLE 8'h0c
`define EIRQ_OFS_GRP_FLAG 8'h10
`define EIRQ_OFS_SEL0 8'h14
`define EIRQ_OFS_SEL1 8'h18
`define EIRQ_OFS_SEL2 8'h1c
`define EIRQ_OFS_SEL3 8'h20
`define EIRQ_OFS_GLOBAL 8'h24
`define EIRQ_OFS_PEND 8'h28
`define EIRQ_OFS_PINS 8'h2c

// Sense selection codes
`define EIRQ_SENSE_LOW 2'h0
`define EIRQ_SENSE_ANY 2'h1
`define EIRQ_SENSE_FALL 2'h2
`define EIRQ_SENSE_RISE 2'h3

// Field positions
`define EIRQ_SENSE_A_LSB 0
`define EIRQ_SENSE_B_LSB 2
`define EIRQ_GLOBAL_BIT 0

// Reset values
`define EIRQ_RST_SENSE 4'h0
`define EIRQ_RST_SELECT 8'h00

// Vector program addresses
`define EIRQ_VEC_RESET 7'h00
`define EIRQ_VEC_LINE_A 7'h01
`define EIRQ_VEC_LINE_B 7'h02
`define EIRQ_VEC_GROUP0 7'h03
`define EIRQ_VEC_WDOG 7'h07
`define EIRQ_VEC_WIDE_CAP 7'h08
`define EIRQ_VEC_NARROW_A 7'h0c
`define EIRQ_VEC_SERIAL 7'h0f
`define EIRQ_VEC_LAST 7'h13
`define EIRQ_NUM_SRC 19

// Timing: pulses must outlast one clock period
`define EIRQ_CLK_PERIOD_NS 8
`define EIRQ_MIN_PULSE_CYC 1

`endif

// ### rtl/eirq_sync.v
`timescale 1ns/1ps
`default_nettype none
module eirq_sync #(
	parameter WIDTH = 1
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;
	// First stage feeds only the second
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ### rtl/eirq_group.v
`timescale 1ns/1ps
`default_nettype none
module eirq_group #(
	parameter WIDTH = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] pins,
	input wire [WIDTH-1:0] pins_prev,
	input wire [WIDTH-1:0] select,
	input wire clear,
	output reg flag
);
	wire toggled;
	// Any selected pin that changed; unselected pins ignored
	assign toggled = |((pins ^ pins_prev) & select);
	always @(posedge aclk) begin
		if (!aresetn) begin
			flag <= 1'b0;
		end else if (toggled) begin
			// Set beats a same-cycle clear
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### testbench/eirq_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eirq_ctrl_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] periph_req,
	input wire logic cpu_reset_entry,
	input wire logic wake_done,
	input wire logic irq_req,
	input wire logic [6:0] irq_vector,
	input wire logic wake_req
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	rd_refuse_a: assert property (rd_take ##0 s_axi_araddr > 32'h2c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	reset_entry_a: assert property (cpu_reset_entry |=> irq_vector == 7'h00 && !irq_req)
		else $error("reset entry not at word zero");
	vec_range_a: assert property (irq_req |-> irq_vector inside {[7'h01:7'h13]})
		else $error("vector outside table");
	wdog_first_a: assert property (periph_req[0] [*3] ##0 irq_req |-> irq_vector <= 7'h07)
		else $error("lower priority served first");
	wake_gate_a: assert property (wake_done [*2] |-> !wake_req)
		else $error("wake while awake");
endmodule
`default_nettype wire

// ### testbench/eirq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module eirq_core_model (
	input wire logic aclk,
	input wire logic take_en,
	input wire logic irq_req,
	input wire logic [6:0] irq_vector,
	output logic vector_taken,
	output logic [6:0] taken_vec
);
	logic [2:0] hold;
	initial begin
		vector_taken = 1'b0;
		taken_vec = 7'h00;
		hold = 3'h0;
	end
	// Back off so a request still draining is not entered twice
	always @(posedge aclk) begin
		vector_taken <= 1'b0;
		if (hold != 3'h0)
			hold <= hold - 3'h1;
		else if (take_en && irq_req) begin
			vector_taken <= 1'b1;
			taken_vec <= irq_vector;
			hold <= 3'h6;
		end
	end
endmodule
`default_nettype wire

// ### testbench/test_irq_vectors_and_external_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "eirq_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_irq_vectors_and_external_irq;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, take_en, vector_taken;
	logic ext_req_line_a, ext_req_line_b, cpu_reset_entry, wake_done, irq_req, wake_req;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, br;
	logic [27:0] pin_change_inputs;
	logic [15:0] periph_req;
	logic [6:0] irq_vector, taken_vec;
	integer miscompares = 0, check_count = 0, i, j;
	eirq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ext_req_line_a(ext_req_line_a), .ext_req_line_b(ext_req_line_b),
		.pin_change_inputs(pin_change_inputs), .periph_req(periph_req), .vector_taken(vector_taken),
		.cpu_reset_entry(cpu_reset_entry), .wake_done(wake_done), .irq_req(irq_req),
		.irq_vector(irq_vector), .wake_req(wake_req));
	eirq_core_model core_u (.aclk(aclk), .take_en(take_en), .irq_req(irq_req), .irq_vector(irq_vector),
		.vector_taken(vector_taken), .taken_vec(taken_vec));
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task tmo(input integer n);
		if (n >= 40) begin
			miscompares++;
			complete_run;
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 40);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		integer n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 40);
		rv = s_axi_rdata;
		s_axi_rready <= 1'b0;
		tmo(n);
		`CHK(rv, e)
	endtask
	// Wait for a request, then optionally let the core enter it
	task automatic wait_vec(input logic [6:0] v, input bit tk);
		integer n;
		n = 0;
		while (irq_req !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
		`CHK(irq_vector, v)
		if (tk) begin
			take_en <= 1'b1;
			n = 0;
			while (vector_taken !== 1'b1 && n < 40) begin
				@(posedge aclk);
				n++;
			end
			take_en <= 1'b0;
			tmo(n);
			`CHK(taken_vec, v)
		end
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		{take_en, cpu_reset_entry, pin_change_inputs, periph_req} = 46'h0;
		{ext_req_line_a, ext_req_line_b, wake_done} = 3'h7;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`EIRQ_OFS_SENSE, 32'h0);
		rchk(`EIRQ_OFS_SEL0, 32'h0);
		wr(32'h40, 32'hff);
		`CHK(br, 2'h2)
		rchk(32'h40, 32'h0);
		wr(32'h100 | `EIRQ_OFS_SENSE, 32'hf);
		`CHK(br, 2'h2)
		s_axi_wstrb <= 4'he;
		wr(`EIRQ_OFS_SENSE, 32'hf);
		`CHK(br, 2'h0)
		s_axi_wstrb <= 4'hf;
		rchk(`EIRQ_OFS_SENSE, 32'h0);
		$display("test reset done");
		wr(`EIRQ_OFS_ENABLE, 32'h1);
		for (i = 1; i < 4; i++) begin
			wr(`EIRQ_OFS_SENSE, i);
			for (j = 0; j < 2; j++) begin
				ext_req_line_a <= j[0];
				repeat (8) @(posedge aclk);
				`CHK(irq_req, 1'b0)
				rchk(`EIRQ_OFS_EXT_FLAG, (j == 0) ? (i != 3) : (i != 2));
				wr(`EIRQ_OFS_EXT_FLAG, 32'h1);
				rchk(`EIRQ_OFS_EXT_FLAG, 32'h0);
			end
		end
		wr(`EIRQ_OFS_GLOBAL, 32'h1);
		wr(`EIRQ_OFS_SENSE, 32'h2);
		ext_req_line_a <= 1'b0;
		wait_vec(7'h01, 1);
		rchk(`EIRQ_OFS_EXT_FLAG, 32'h0);
		$display("test edge senses done");
		// Line A must idle high before low-level sense, or it requests at once
		ext_req_line_a <= 1'b1;
		wr(`EIRQ_OFS_SENSE, 32'h0);
		wr(`EIRQ_OFS_ENABLE, 32'h3);
		wake_done <= 1'b0;
		ext_req_line_b <= 1'b0;
		wait_vec(7'h02, 1);
		repeat (8) @(posedge aclk);
		`CHK(irq_req, 1'b1)
		`CHK(wake_req, 1'b1)
		rchk(`EIRQ_OFS_EXT_FLAG, 32'h0);
		ext_req_line_b <= 1'b1;
		repeat (8) @(posedge aclk);
		`CHK(irq_req, 1'b0)
		wake_done <= 1'b1;
		wr(`EIRQ_OFS_ENABLE, 32'h0);
		`CHK(wake_req, 1'b0)
		$display("test low level done");
		for (i = 0; i < 4; i++) begin
			wr(`EIRQ_OFS_SEL0 + 4 * i, 32'h2);
			wr(`EIRQ_OFS_GRP_ENABLE, 32'h1 << i);
			pin_change_inputs <= pin_change_inputs ^ (28'h1 << (8 * i));
			repeat (8) @(posedge aclk);
			`CHK(irq_req, 1'b0)
			pin_change_inputs <= pin_change_inputs ^ (28'h2 << (8 * i));
			wait_vec(7'h03 + i, 1);
		end
		wr(`EIRQ_OFS_GRP_ENABLE, 32'h0);
		rchk(`EIRQ_OFS_PINS, 32'h33030303);
		$display("test pin groups done");
		for (i = 0; i < 14; i++) begin
			periph_req <= (i == 13) ? 16'h1001 : 16'h1 << i;
			repeat (4) @(posedge aclk);
			wait_vec((i == 13) ? 7'h07 : 7'h07 + i, 0);
		end
		rchk(`EIRQ_OFS_PEND, 32'h40040);
		cpu_reset_entry <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK(irq_vector, 7'h00)
		`CHK(irq_req, 1'b0)
		cpu_reset_entry <= 1'b0;
		periph_req <= 16'h0;
		$display("test vectors done");
		complete_run;
	end
endmodule
bind eirq_ctrl eirq_ctrl_checker chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .periph_req(periph_req), .cpu_reset_entry(cpu_reset_entry),
	.wake_done(wake_done), .irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));
`default_nettype wire
